/* File: inc/dsw_pkg.sv */
package dsw_pkg;

  // =====================================================================
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS  = 16;
  localparam int MODE_LSB   = 16;
  localparam int MODE_MSB   = 17;
  localparam int CNT_BITS   = 5;

  // =====================================================================
  // reset values
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [1:0]  MODE_RESET = 2'h0;

  // =====================================================================
  // power modes
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_PD_1K    = 2'b01,
    MODE_PD_100K  = 2'b10,
    MODE_HIGH_Z   = 2'b11
  } dsw_mode_e;

  // =====================================================================
  // frame states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } dsw_state_e;

endpackage

/* File: hw/dsw_serial_port.sv */
// How it works
// - frame select falling, edge sensitive, opens a frame for the shifter
// - each of the first 24 serial clock falling edges in a frame shifts one data bit, later ones are ignored
// - on the 24th falling edge code and mode update together
// - frame select rising before 24th edge discards the partial frame
// - frame is msb first: six ignored, two mode, sixteen code bits
// - mode 00 normal, 01 1k, 10 100k, 11 high impedance
// - reset clears code and mode to zero until a full frame
module dsw_serial_port #(
  parameter int CODE_W = 16
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  // serial pins
  input  wire logic              syncN,
  input  wire logic              sclk,
  input  wire logic              sdin,
  // converter side
  output logic      [CODE_W-1:0] dacCode,
  output logic      [1:0]        powerMode,
  output logic                   updatePulse,
  output logic                   abortPulse
);

  // =====================================================================
  // pin synchronisers: three stages, change taken when 2nd and 3rd agree
  logic [2:0] syncSr;
  logic [2:0] sclkSr;
  logic [2:0] dinSr;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncSr <= 3'h7;
      sclkSr <= 3'h0;
      dinSr  <= 3'h0;
    end
    else if (clkEn)
    begin
      syncSr <= {syncSr[1:0], syncN};
      sclkSr <= {sclkSr[1:0], sclk};
      dinSr  <= {dinSr[1:0], sdin};
    end
  end

  // filtered levels
  logic syncLvl_q;
  logic sclkLvl_q;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncLvl_q <= 1'b1;
      sclkLvl_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (syncSr[1] == syncSr[2])
        syncLvl_q <= syncSr[2];
      if (sclkSr[1] == sclkSr[2])
        sclkLvl_q <= sclkSr[2];
    end
  end

  logic sclkFall;
  logic syncFall;
  logic syncRise;

  assign sclkFall = sclkLvl_q && (sclkSr[1] == sclkSr[2]) && !sclkSr[2];
  assign syncFall = syncLvl_q && (syncSr[1] == syncSr[2]) && !syncSr[2];
  assign syncRise = !syncLvl_q && (syncSr[1] == syncSr[2]) && syncSr[2];

  // =====================================================================
  // frame state machine
  dsw_pkg::dsw_state_e                   state_q;
  logic [dsw_pkg::CNT_BITS-1:0]          bitCnt_q;
  logic [dsw_pkg::FRAME_BITS-1:0]        shReg_q;
  logic                                  lastEdge;

  assign lastEdge = sclkFall &&
    (bitCnt_q == 5'(dsw_pkg::FRAME_BITS - 1));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q  <= dsw_pkg::ST_IDLE;
      bitCnt_q <= 5'h00;
      shReg_q  <= 24'h000000;
    end
    else if (clkEn)
    begin
      case (state_q)
        dsw_pkg::ST_IDLE:
        begin
          if (syncFall)
          begin
            state_q  <= dsw_pkg::ST_SHIFT;
            bitCnt_q <= 5'h00;
          end
        end
        dsw_pkg::ST_SHIFT:
        begin
          if (syncRise)
          begin
            state_q  <= dsw_pkg::ST_IDLE;
            bitCnt_q <= 5'h00;
            shReg_q  <= 24'h000000;
          end
          else if (sclkFall)
          begin
            shReg_q  <= {shReg_q[dsw_pkg::FRAME_BITS-2:0], dinSr[2]};
            bitCnt_q <= bitCnt_q + 5'h01;
            if (lastEdge)
              state_q <= dsw_pkg::ST_DONE;
          end
        end
        dsw_pkg::ST_DONE:
        begin
          if (syncRise)
          begin
            state_q  <= dsw_pkg::ST_IDLE;
            bitCnt_q <= 5'h00;
          end
        end
        default:
        begin
          state_q  <= dsw_pkg::ST_IDLE;
          bitCnt_q <= 5'h00;
        end
      endcase
    end
  end

  // =====================================================================
  // converter registers
  logic [dsw_pkg::FRAME_BITS-1:0] fullWord;

  assign fullWord = {shReg_q[dsw_pkg::FRAME_BITS-2:0], dinSr[2]};

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      dacCode   <= CODE_W'(dsw_pkg::CODE_RESET);
      powerMode <= dsw_pkg::MODE_RESET;
    end
    else if (clkEn)
    begin
      if (state_q == dsw_pkg::ST_SHIFT && !syncRise && lastEdge)
      begin
        dacCode   <= fullWord[CODE_W-1:0];
        powerMode <= fullWord[dsw_pkg::MODE_MSB:dsw_pkg::MODE_LSB];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      updatePulse <= 1'b0;
      abortPulse  <= 1'b0;
    end
    else if (clkEn)
    begin
      updatePulse <= (state_q == dsw_pkg::ST_SHIFT) && !syncRise &&
                     lastEdge;
      abortPulse  <= (state_q == dsw_pkg::ST_SHIFT) && syncRise;
    end
    else
    begin
      updatePulse <= 1'b0;
      abortPulse  <= 1'b0;
    end
  end

  // =====================================================================
  // checks
  a_update_on_last: assert property (
    @(posedge mclk) disable iff (!nrst)
    (clkEn && state_q == dsw_pkg::ST_SHIFT && !syncRise && lastEdge)
      |=> updatePulse && state_q == dsw_pkg::ST_DONE)
    else $error("update not taken on last edge");

  a_abort_keeps_code: assert property (
    @(posedge mclk) disable iff (!nrst)
    (clkEn && state_q == dsw_pkg::ST_SHIFT && syncRise)
      |=> $stable(dacCode) && $stable(powerMode) && abortPulse
          && bitCnt_q == 5'h00)
    else $error("abort changed outputs");

  a_code_only_update: assert property (
    @(posedge mclk) disable iff (!nrst)
    !updatePulse |-> $stable(dacCode) || !$past(nrst))
    else $error("code changed without update");

  a_done_ignores: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_q == dsw_pkg::ST_DONE && !syncRise) |=>
      state_q == dsw_pkg::ST_DONE && $stable(dacCode))
    else $error("edges not ignored after frame");

  a_count_shift: assert property (
    @(posedge mclk) disable iff (!nrst)
    (clkEn && state_q == dsw_pkg::ST_SHIFT && sclkFall && !syncRise)
      |=> bitCnt_q == $past(bitCnt_q) + 5'h01)
    else $error("bit count did not advance");

  a_frame_open: assert property (
    @(posedge mclk) disable iff (!nrst)
    (clkEn && state_q == dsw_pkg::ST_IDLE && syncFall)
      |=> state_q == dsw_pkg::ST_SHIFT && bitCnt_q == 5'h00)
    else $error("frame did not open");

  a_mode_field: assert property (
    @(posedge mclk) disable iff (!nrst)
    updatePulse |->
      powerMode == $past(fullWord[dsw_pkg::MODE_MSB:dsw_pkg::MODE_LSB]))
    else $error("mode field wrong");

  a_code_field: assert property (
    @(posedge mclk) disable iff (!nrst)
    updatePulse |-> dacCode == $past(fullWord[CODE_W-1:0]))
    else $error("code field wrong");

endmodule // dsw_serial_port

/* File: dv/dsw_host_model.sv */
module dsw_host_model (
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      syncN,
  output logic      sclk,
  output logic      sdin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ====================================================================
  // serial master
  initial
  begin
    syncN = 1'h1;
    sclk  = 1'h1;
    sdin  = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // 4 mclk high, 4 low keeps sclk slow
  task automatic frame(input logic [23:0] w, input int n);
    int i;
    syncN = 1'h0;
    wt(4);
    for (i = 0; i < n; i++)
    begin
      sdin = (i < 24) ? w[23 - i] : ~w[0];
      wt(3);
      sclk = 1'h0;
      wt(4);
      sclk = 1'h1;
      wt(1);
    end
    // release, idle gap past 100 ns
    syncN = 1'h1;
    sdin  = ~sdin;
    wt(14);
  endtask
endmodule // dsw_host_model

/* File: dv/dsw_serial_port_bench.sv */
module dsw_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ====================================================================
  // harness
  logic        mclk = 1'h0;
  logic        nrst = 1'h0;
  logic        clkEn = 1'h1;
  logic        syncN;
  logic        sclk;
  logic        sdin;
  logic [15:0] dacCode;
  logic [1:0]  powerMode;
  logic        updatePulse;
  logic        abortPulse;
  int          mismatches = 0;
  int          cmpCount = 0;
  int          upd = 0;
  int          abt = 0;

  always #4 mclk = ~mclk;

  // pulses last one mclk period, so mid-period sampling sees each once
  always @(negedge mclk)
  begin
    if (updatePulse === 1'h1) upd++;
    if (abortPulse === 1'h1) abt++;
  end

  dsw_serial_port #(.CODE_W(16)) u_dsw_serial_port (
    .mclk(mclk), .nrst(nrst), .clkEn(clkEn), .syncN(syncN), .sclk(sclk),
    .sdin(sdin), .dacCode(dacCode), .powerMode(powerMode),
    .updatePulse(updatePulse), .abortPulse(abortPulse));

  dsw_host_model u_dsw_host_model (
    .mclk(mclk), .syncN(syncN), .sclk(sclk), .sdin(sdin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ====================================================================
  // scenarios
  task automatic t_reset();
    chk({14'h0, powerMode, dacCode}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_modes();
    int          m;
    logic [15:0] c;
    for (m = 0; m < 4; m++)
    begin
      c = 16'h8001 + 16'h1111 * m[15:0];
      u_dsw_host_model.frame({6'h3F, m[1:0], c}, 24);
      chk({14'h0, powerMode, dacCode}, {14'h0, m[1:0], c});
      chk(upd, m + 1);
    end
    $display("mode test done");
  endtask

  task automatic t_abort();
    u_dsw_host_model.frame(24'hFFFFFF, 23);
    chk({14'h0, powerMode, dacCode}, 32'h3B334);
    chk(abt, 32'h1);
    chk(upd, 32'h4);
    $display("abort test done");
  endtask

  task automatic t_extra();
    u_dsw_host_model.frame(24'h011234, 30);
    chk({14'h0, powerMode, dacCode}, 32'h11234);
    u_dsw_host_model.frame(24'h000000, 24);
    chk({14'h0, powerMode, dacCode}, 32'h0);
    chk(upd, 32'h6);
    $display("extra clock test done");
  endtask

  // frozen block must not see a frame, then must take the next one
  task automatic t_freeze();
    clkEn = 1'h0;
    u_dsw_host_model.frame(24'h02ABCD, 24);
    clkEn = 1'h1;
    repeat (4) @(negedge mclk);
    chk({14'h0, powerMode, dacCode}, 32'h0);
    chk(upd, 32'h6);
    u_dsw_host_model.frame(24'h02ABCD, 24);
    chk({14'h0, powerMode, dacCode}, 32'h2ABCD);
    chk(upd, 32'h7);
    $display("clock enable test done");
  endtask

  initial
  begin
    repeat (8) @(negedge mclk);
    nrst = 1'h1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_modes();
    t_abort();
    t_extra();
    t_freeze();
    summarize();
  end
endmodule // dsw_serial_port_bench
